// [rtl/ceig_din_filter.sv]
`timescale 1ns/1ps
`default_nettype none

module ceig_din_filter (
    // clock and reset
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               ce,
    // settings
    input  wire ceig_pkg::ceig_cnt_t thresh,
    input  wire logic               bypass,
    // inputs
    input  wire logic [2:0]         raw,
    output logic      [2:0]         filt
);

    ceig_pkg::ceig_cnt_t cnt_q [3];
    ceig_pkg::ceig_cnt_t cnt_d [3];
    logic [2:0]          filt_d;

    // a level is taken over only after it held for thresh cycles in a row
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cnt_d[i]  = '0;
            filt_d[i] = filt[i];
            if (bypass) begin
                filt_d[i] = raw[i];
            end else if (raw[i] != filt[i]) begin
                if (cnt_q[i] + 23'h1 >= thresh) begin
                    filt_d[i] = raw[i];
                end else begin
                    cnt_d[i] = cnt_q[i] + 23'h1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 3; i++) begin
                cnt_q[i] <= '0;
            end
            filt <= 3'h0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            filt  <= filt_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/ceig_event_irq.sv]
// The register addresses and the AHB-Lite register port were decided locally.
`include "ceig_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ceig_event_irq #(
    parameter int unsigned DLY1_CYC = `CEIG_T_F1_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY2_CYC = `CEIG_T_F2_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY3_CYC = `CEIG_T_F3_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY4_CYC = `CEIG_T_F4_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY5_CYC = `CEIG_T_F5_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY6_CYC = `CEIG_T_F6_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY7_CYC = `CEIG_T_F7_NS / `CEIG_CLK_NS,
    parameter int unsigned DLY8_CYC = `CEIG_T_F8_NS / `CEIG_CLK_NS
) (
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // counter feedback
    input  wire logic        gate_open,
    input  wire logic        overflow_ev,
    input  wire logic        underflow_ev,
    input  wire logic        compare_output_first_ev,
    input  wire logic        compare_output_second_ev,
    input  wire logic        zero_pass_ev,
    input  wire logic        capture_ev,
    input  wire logic        sync_ev,
    input  wire logic        count_step,
    input  wire logic        count_down,
    // standard digital inputs
    input  wire logic [2:0]  din_raw,
    output logic      [2:0]  din_filt,
    // to the controller
    output logic             irq,
    output logic [3:0]       event_class_code,
    output logic             count_direction_flag
);

    // lowest pending enabled code is reported first
    function automatic ceig_pkg::ceig_code_t code_of(input ceig_pkg::ceig_evvec_t v);
        ceig_pkg::ceig_code_t c;
        c = `CEIG_CODE_NONE;
        for (int i = 9; i >= 0; i--) begin
            if (v[i]) begin
                c = 4'(i + 1);
            end
        end
        return c;
    endfunction

    function automatic ceig_pkg::ceig_cnt_t thresh_of(input logic [3:0] s);
        unique case (s)
            ceig_pkg::CEIG_FLT_50US:  thresh_of = 23'(DLY1_CYC);
            ceig_pkg::CEIG_FLT_100US: thresh_of = 23'(DLY2_CYC);
            ceig_pkg::CEIG_FLT_400US: thresh_of = 23'(DLY3_CYC);
            ceig_pkg::CEIG_FLT_800US: thresh_of = 23'(DLY4_CYC);
            ceig_pkg::CEIG_FLT_1M6:   thresh_of = 23'(DLY5_CYC);
            ceig_pkg::CEIG_FLT_3M2:   thresh_of = 23'(DLY6_CYC);
            ceig_pkg::CEIG_FLT_12M8:  thresh_of = 23'(DLY7_CYC);
            ceig_pkg::CEIG_FLT_20MS:  thresh_of = 23'(DLY8_CYC);
            default:                  thresh_of = 23'h0;
        endcase
    endfunction

    // bus state
    logic        wr_q, wr_d;
    logic [7:0]  waddr_q, waddr_d;
    logic [31:0] rdata_d;
    logic [31:0] ctrl_q, ctrl_d;
    ceig_pkg::ceig_evvec_t ien_q, ien_d;
    ceig_pkg::ceig_evvec_t pend_q, pend_d;
    ceig_pkg::ceig_evvec_t lost_q, lost_d;
    ceig_pkg::ceig_evvec_t ev, ack, lack;
    // event state
    logic        gate_q, gate_d;
    logic        dir_q, dir_d;
    logic        dir_seen_q, dir_seen_d;
    logic        rev;
    logic [3:0]  fsel;
    logic        acc;
    logic [7:0]  raddr;
    logic        ien_wr;

    assign fsel  = ctrl_q[`CEIG_CTRL_FSEL_MSB:`CEIG_CTRL_FSEL_LSB];
    assign acc   = hsel & hready & htrans[1];
    assign raddr = haddr[7:0];
    // an enable write in flight may legally mask an event in the same cycle
    assign ien_wr = wr_q && (waddr_q == `CEIG_OFS_IEN);

    // direction: first step only learns the direction, later changes are reversals
    always_comb begin
        dir_d      = dir_q;
        dir_seen_d = dir_seen_q;
        rev        = 1'b0;
        if (count_step) begin
            dir_d      = count_down;
            dir_seen_d = 1'b1;
            rev        = dir_seen_q & (count_down != dir_q);
        end
        gate_d = gate_open;
    end

    // raw events by class code, bit n-1 is code n
    always_comb begin
        ev     = '0;
        ev[0]  = gate_open & ~gate_q;
        ev[1]  = ~gate_open & gate_q;
        ev[2]  = overflow_ev;
        ev[3]  = underflow_ev;
        ev[4]  = compare_output_first_ev;
        ev[5]  = compare_output_second_ev;
        ev[6]  = zero_pass_ev;
        ev[7]  = capture_ev & ctrl_q[`CEIG_CTRL_MODE_BIT];
        ev[8]  = sync_ev;
        ev[9]  = rev;
    end

    // bus writes land in the data phase; reads are latched in the address phase
    always_comb begin
        wr_d    = acc & hwrite;
        waddr_d = acc ? raddr : waddr_q;
        ctrl_d  = ctrl_q;
        ien_d   = ien_q;
        ack     = '0;
        lack    = '0;
        if (wr_q) begin
            unique case (waddr_q)
                `CEIG_OFS_CTRL: ctrl_d = hwdata & 32'h0000_00F1;
                `CEIG_OFS_IEN:  ien_d  = hwdata[9:0];
                `CEIG_OFS_PEND: ack    = hwdata[9:0];
                `CEIG_OFS_LOST: lack   = hwdata[9:0];
                default: ;
            endcase
        end
        rdata_d = hrdata;
        if (acc & ~hwrite) begin
            unique case (raddr)
                `CEIG_OFS_CTRL: rdata_d = ctrl_q;
                `CEIG_OFS_IEN:  rdata_d = {22'h0, ien_q};
                `CEIG_OFS_PEND: rdata_d = {22'h0, pend_q};
                `CEIG_OFS_LOST: rdata_d = {22'h0, lost_q};
                `CEIG_OFS_CODE: rdata_d = {28'h0, event_class_code};
                `CEIG_OFS_DIN:  rdata_d = {29'h0, din_filt};
                default:        rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // raising: only enabled, only when not already pending; set beats acknowledge
    always_comb begin
        pend_d = (pend_q & ~ack) | (ev & ien_q);
        lost_d = (lost_q & ~lack) | (ev & ien_q & pend_q & ~ack);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q                 <= 1'b0;
            waddr_q              <= 8'h00;
            hrdata               <= 32'h0000_0000;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
            ctrl_q               <= `CEIG_CTRL_RST;
            ien_q                <= `CEIG_IEN_RST;
            pend_q               <= '0;
            lost_q               <= '0;
            gate_q               <= 1'b0;
            dir_q                <= 1'b0;
            dir_seen_q           <= 1'b0;
            irq                  <= 1'b0;
            event_class_code     <= `CEIG_CODE_NONE;
            count_direction_flag <= 1'b0;
        end else if (ce) begin
            wr_q                 <= wr_d;
            waddr_q              <= waddr_d;
            hrdata               <= rdata_d;
            hreadyout            <= 1'b1;
            hresp                <= 1'b0;
            ctrl_q               <= ctrl_d;
            ien_q                <= ien_d;
            pend_q               <= pend_d;
            lost_q               <= lost_d;
            gate_q               <= gate_d;
            dir_q                <= dir_d;
            dir_seen_q           <= dir_seen_d;
            irq                  <= |(pend_d & ien_d);
            event_class_code     <= code_of(pend_d & ien_d);
            count_direction_flag <= dir_d;
        end
    end

    // filter delay chosen by the control register
    ceig_din_filter u_filter (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .thresh  (thresh_of(fsel)),
        .bypass  (fsel == 4'(ceig_pkg::CEIG_FLT_NONE) || fsel > 4'h8),
        .raw     (din_raw),
        .filt    (din_filt)
    );

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_gate_rise;
        ce && gate_open && !gate_q && ien_q[0] && !ien_wr;
    endsequence

    sequence s_first_down;
        ce && count_step && count_down && !dir_seen_q;
    endsequence

    sequence s_reversal;
        ce && count_step && dir_seen_q && (count_down != dir_q) && ien_q[9] && !ien_wr;
    endsequence

    AST_GATE_OPEN_RAISES: assert property (s_gate_rise |=> pend_q[0] && irq)
        else $error("gate opening did not raise code 1");

    AST_IRQ_IS_UNMASKED_PEND: assert property (irq == |(pend_q & ien_q))
        else $error("interrupt output disagrees with pending and enable");

    AST_CODE_LOWEST: assert property (event_class_code == code_of(pend_q & ien_q))
        else $error("event class code not the lowest pending enabled code");

    AST_DISABLED_SILENT: assert property (
        ce && !ien_q[4] && !pend_q[4] && !(wr_q && waddr_q == `CEIG_OFS_IEN) |=> !pend_q[4])
        else $error("disabled event type became pending");

    AST_DUP_LOST: assert property (
        ce && ev[6] && ien_q[6] && pend_q[6] && !ack[6] |=> lost_q[6] && pend_q[6])
        else $error("duplicate event not recorded as lost");

    AST_CAPTURE_MODE: assert property (
        ce && capture_ev && !ctrl_q[`CEIG_CTRL_MODE_BIT] && !pend_q[7] |=> !pend_q[7])
        else $error("capture event raised outside counting mode");

    AST_FIRST_DOWN_QUIET: assert property (s_first_down |=> !pend_q[9] ##1 dir_seen_q)
        else $error("first down step raised a reversal");

    AST_ACK_CLEARS: assert property (
        ce && ack[2] && !ev[2] |=> !pend_q[2])
        else $error("acknowledge did not clear pending flag");

    AST_SET_BEATS_ACK: assert property (
        ce && ack[3] && ev[3] && ien_q[3] |=> pend_q[3] && !lost_q[3] || $past(lost_q[3]))
        else $error("event lost against acknowledge in same cycle");

    AST_RESET_DISABLED: assert property ($rose(hresetn) |-> ien_q == '0)
        else $error("events enabled after reset");

    AST_FILTER_HOLDS: assert property (
        ce && fsel == 4'h1 && din_raw[0] != din_filt[0] && $stable(din_raw[0])
        |=> din_filt[0] == $past(din_filt[0]) || u_filter.cnt_q[0] == '0)
        else $error("filter passed a level before the delay ran out");

    AST_GATE_CLOSE_RAISES: assert property (
        ce && !gate_open && gate_q && ien_q[1] && !ien_wr |=> pend_q[1])
        else $error("gate closing did not raise code 2");

    AST_OVERFLOW_RAISES: assert property (
        ce && overflow_ev && ien_q[2] && !ien_wr |=> pend_q[2] && irq)
        else $error("overflow did not raise code 3");

    AST_REVERSAL_RAISES: assert property (s_reversal |=> pend_q[9] && irq)
        else $error("direction reversal did not raise code 10");

    AST_DIR_FLAG: assert property (
        ce && count_step |=> count_direction_flag == $past(count_down))
        else $error("direction flag does not follow the last count step");

    AST_LOST_STICKY: assert property (ce && lost_q[6] && !lack[6] |=> lost_q[6])
        else $error("lost flag dropped without a clear");

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("register bus answered with a wait or an error");

    AST_FILTER_BYPASS: assert property (
        ce && fsel == 4'h0 |=> din_filt == $past(din_raw))
        else $error("unfiltered input not passed after one cycle");

endmodule

`default_nettype wire

// [rtl/ceig_pkg.sv]
package ceig_pkg;

    typedef logic [9:0]  ceig_evvec_t;
    typedef logic [22:0] ceig_cnt_t;
    typedef logic [3:0]  ceig_code_t;

    typedef enum logic [3:0] {
        CEIG_FLT_NONE,
        CEIG_FLT_50US,
        CEIG_FLT_100US,
        CEIG_FLT_400US,
        CEIG_FLT_800US,
        CEIG_FLT_1M6,
        CEIG_FLT_3M2,
        CEIG_FLT_12M8,
        CEIG_FLT_20MS
    } ceig_fsel_t;

endpackage

// [rtl/ceig_regs.svh]
`ifndef CEIG_REGS_SVH
`define CEIG_REGS_SVH

// register byte offsets
`define CEIG_OFS_CTRL       8'h00
`define CEIG_OFS_IEN        8'h04
`define CEIG_OFS_PEND       8'h08
`define CEIG_OFS_LOST       8'h0C
`define CEIG_OFS_CODE       8'h10
`define CEIG_OFS_DIN        8'h14

// control register fields
`define CEIG_CTRL_MODE_BIT  0
`define CEIG_CTRL_FSEL_LSB  4
`define CEIG_CTRL_FSEL_MSB  7

// reset values
`define CEIG_CTRL_RST       32'h0000_0000
`define CEIG_IEN_RST        10'h000
`define CEIG_CODE_NONE      4'h0

// event class codes
`define CEIG_EV_GATE_OPEN   4'h1
`define CEIG_EV_GATE_CLOSE  4'h2
`define CEIG_EV_OVERFLOW    4'h3
`define CEIG_EV_UNDERFLOW   4'h4
`define CEIG_EV_CMP_FIRST   4'h5
`define CEIG_EV_CMP_SECOND  4'h6
`define CEIG_EV_ZERO        4'h7
`define CEIG_EV_CAPTURE     4'h8
`define CEIG_EV_SYNC        4'h9
`define CEIG_EV_DIR_REV     4'hA

// timing: clock period and input filter delays, all in ns
`define CEIG_CLK_NS         5
`define CEIG_T_F1_NS        50000
`define CEIG_T_F2_NS        100000
`define CEIG_T_F3_NS        400000
`define CEIG_T_F4_NS        800000
`define CEIG_T_F5_NS        1600000
`define CEIG_T_F6_NS        3200000
`define CEIG_T_F7_NS        12800000
`define CEIG_T_F8_NS        20000000

`endif

// [test/ceig_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ceig_host_model (
    // clock and bus answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // one single word transfer; no latency assumed, only hready ends a phase
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        if (wr)
            hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
endmodule

`default_nettype wire

// [test/counter_event_interrupt_gen_bench.sv]
`include "ceig_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module counter_event_interrupt_gen_bench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        ce = 1'b1;
    logic        gate_open = 1'b0;
    logic [9:0]  ev = 10'h000;
    logic        count_down = 1'b0;
    logic [2:0]  din_raw = 3'h0;
    logic [2:0]  din_filt;
    logic        hsel, hwrite, hreadyout, hresp, irq, dir_flag;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize, nv, old;
    logic [3:0]  code;
    logic [9:0]  m, v;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cnt;

    always #2.5 hclk = ~hclk;

    ceig_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // short filter counts keep the run brief; the three longest keep their real counts
    ceig_event_irq #(.DLY1_CYC(4), .DLY2_CYC(5), .DLY3_CYC(6), .DLY4_CYC(7),
        .DLY5_CYC(8)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .gate_open(gate_open), .overflow_ev(ev[2]),
        .underflow_ev(ev[3]), .compare_output_first_ev(ev[4]),
        .compare_output_second_ev(ev[5]), .zero_pass_ev(ev[6]),
        .capture_ev(ev[7]), .sync_ev(ev[8]), .count_step(ev[9]),
        .count_down(count_down), .din_raw(din_raw), .din_filt(din_filt),
        .irq(irq), .event_class_code(code), .count_direction_flag(dir_flag));

    function automatic logic [31:0] low_code(input logic [9:0] p);
        for (int i = 0; i < 10; i++) begin
            if (p[i])
                return 32'(i + 1);
        end
        return 32'h0000_0000;
    endfunction

    // settings 6..8 take far longer than the 40-cycle watch: 0 means the level must hold
    function automatic int flt_len(input int f);
        if (f == 0 || f > 8)
            return 1;
        return (f < 6) ? f + 3 : 0;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        host_u.xfer(1'b1, a, d, dummy);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host_u.xfer(1'b0, a, 32'h0000_0000, d);
    endtask

    // one-cycle event pulse, then outputs are looked at once settled
    task automatic pulse(input logic [9:0] p);
        @(posedge hclk);
        ev <= p;
        @(posedge hclk);
        ev <= 10'h000;
        @(posedge hclk);
        #1;
    endtask

    task automatic ack(input logic [9:0] p);
        wr(`CEIG_OFS_PEND, {22'h00_0000, p});
        rd(`CEIG_OFS_PEND, r);
        chk("pend_clr", r, 32'h0000_0000);
        chk("irq_clr", {31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h3B6D827C));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`CEIG_OFS_IEN, r);
        chk("ien_rst", r, 32'h0000_0000);
        pulse(10'h004);
        chk("irq_off", {31'h0, irq}, 32'h0000_0000);
        wr(`CEIG_OFS_IEN, 32'h0000_03FF);
        count_down <= 1'b1;
        pulse(10'h200);
        chk("dir_flag", {31'h0, dir_flag}, 32'h0000_0001);
        chk("first_down", {31'h0, irq}, 32'h0000_0000);
        count_down <= 1'b0;
        pulse(10'h200);
        chk("dir_rev", {28'h0, code}, 32'h0000_000A);
        ack(10'h200);
        // each pulse type from overflow to sync alone, capture needs counting mode
        wr(`CEIG_OFS_CTRL, 32'h0000_0001);
        for (int k = 2; k < 9; k++) begin
            pulse(10'(1 << k));
            chk("code", {28'h0, code}, 32'(k + 1));
            chk("irq", {31'h0, irq}, 32'h0000_0001);
            rd(`CEIG_OFS_PEND, r);
            chk("pend", r, 32'(1 << k));
            ack(10'(1 << k));
        end
        gate_open <= 1'b1;
        pulse(10'h000);
        chk("gate_up", {28'h0, code}, 32'h0000_0001);
        ack(10'h001);
        gate_open <= 1'b0;
        pulse(10'h000);
        chk("gate_dn", {28'h0, code}, 32'h0000_0002);
        ack(10'h002);
        wr(`CEIG_OFS_CTRL, 32'h0000_0000);
        pulse(10'h080);
        rd(`CEIG_OFS_PEND, r);
        chk("cap_nomode", r, 32'h0000_0000);
        // second identical event while unprocessed is dropped and marked lost
        pulse(10'h040);
        pulse(10'h040);
        rd(`CEIG_OFS_LOST, r);
        chk("lost", r, 32'h0000_0040);
        wr(`CEIG_OFS_LOST, 32'h0000_0040);
        ack(10'h040);
        // a frozen block takes no event at all
        ce <= 1'b0;
        pulse(10'h040);
        chk("ce_freeze", {31'h0, irq}, 32'h0000_0000);
        ce <= 1'b1;
        rd(`CEIG_OFS_PEND, r);
        chk("ce_pend", r, 32'h0000_0000);
        // an event landing with its own acknowledge stays pending, not lost
        pulse(10'h008);
        fork
            wr(`CEIG_OFS_PEND, 32'h0000_0008);
            begin
                repeat (2) @(posedge hclk);
                ev <= 10'h008;
                @(posedge hclk);
                ev <= 10'h000;
            end
        join
        rd(`CEIG_OFS_PEND, r);
        chk("set_wins", r, 32'h0000_0008);
        rd(`CEIG_OFS_LOST, r);
        chk("set_not_lost", r, 32'h0000_0000);
        ack(10'h008);
        wr(`CEIG_OFS_CTRL, 32'h0000_0001);
        repeat (20) begin
            m = 10'($urandom);
            v = 10'($urandom) & 10'h1FC;
            wr(`CEIG_OFS_IEN, {22'h00_0000, m});
            chk("hresp", {31'h0, hresp}, 32'h0000_0000);
            pulse(v);
            rd(`CEIG_OFS_PEND, r);
            chk("mix_pend", r, {22'h00_0000, m & v});
            rd(`CEIG_OFS_CODE, r);
            chk("mix_code_reg", r, low_code(m & v));
            chk("mix_code", {28'h0, code}, low_code(m & v));
            chk("mix_irq", {31'h0, irq}, {31'h0, |(m & v)});
            ack(m & v);
        end
        for (int f = 0; f < 10; f++) begin
            wr(`CEIG_OFS_CTRL, 32'(f << 4));
            old = din_filt;
            nv = din_filt ^ 3'(($urandom % 7) + 1);
            @(posedge hclk);
            din_raw <= nv;
            cnt = 0;
            do begin
                @(posedge hclk);
                #1;
                cnt++;
            end while (din_filt !== nv && cnt < 40);
            if (flt_len(f) > 0) begin
                chk("flt_len", {31'h0, cnt >= flt_len(f) && cnt <= flt_len(f) + 2},
                    32'h0000_0001);
                rd(`CEIG_OFS_DIN, r);
                chk("din_reg", r, {29'h0, nv});
            end else begin
                chk("flt_hold", {29'h0, din_filt}, {29'h0, old});
            end
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
